// file: core/crt_pkg.sv
package crt_pkg;
   // apb byte offsets
   localparam logic [7:0] ADDR_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_MODE    = 8'h04;
   localparam logic [7:0] ADDR_COUNT   = 8'h08;
   localparam logic [7:0] ADDR_RELOAD  = 8'h0c;
   // control register bit positions
   localparam int CTL_RELOAD_SEL = 0;
   localparam int CTL_COUNTER    = 1;
   localparam int CTL_RUN        = 2;
   localparam int CTL_EDGE_EN    = 3;
   localparam int CTL_TX_BAUD    = 4;
   localparam int CTL_RX_BAUD    = 5;
   localparam int CTL_EDGE_FLAG  = 6;
   localparam int CTL_OVF_FLAG   = 7;
   // mode register bit positions
   localparam int MOD_DOWN_EN    = 0;
   localparam int MOD_CLKOUT_EN  = 1;
   // reset values
   localparam logic [7:0]  CONTROL_RESET = 8'h00;
   localparam logic [1:0]  MODE_RESET    = 2'h0;
   localparam logic [15:0] COUNT_RESET   = 16'h0000;
   localparam logic [15:0] RELOAD_RESET  = 16'h0000;
   localparam logic [15:0] COUNT_TOP     = 16'hffff;
   // oscillator periods per tick; rollovers per baud bit
   localparam int MACHINE_CYCLE_OSC = 12;
   localparam int STATE_TIME_OSC    = 2;
   localparam int BAUD_DIVIDE       = 16;
   localparam int PRESCALE_W        = 4;
   localparam logic [PRESCALE_W-1:0] MACHINE_LAST =
      PRESCALE_W'(MACHINE_CYCLE_OSC - 1);
   localparam logic [PRESCALE_W-1:0] BAUD_LAST =
      PRESCALE_W'(BAUD_DIVIDE - 1);
   localparam int SYNC_STAGES = 3;
endpackage : crt_pkg

// file: core/crt_pin_sync.sv
`timescale 1ns/100ps
module crt_pin_sync (
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic clkEn,
   input  wire logic pinIn,
   output logic      pinLevel
);
   logic [crt_pkg::SYNC_STAGES-1:0] stage;

   // stage[0] feeds only stage[1]; level changes once 2nd and 3rd agree
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         stage    <= '0;
         pinLevel <= 1'b0;
      end else if (clkEn) begin
         stage <= {stage[crt_pkg::SYNC_STAGES-2:0], pinIn};
         if (stage[2] == stage[1]) begin
            pinLevel <= stage[2];
         end
      end
   end
endmodule : crt_pin_sync

// file: core/crt_timer.sv
`timescale 1ns/100ps
// Overview of operation
// - capture mode: 16-bit count, overflow sets flag
// - trigger fall captures count into reload
// - capture edge sets edge flag, may interrupt
// - reset clears down_count_enable, counts upward
// - up auto-reload: overflow sets flag, reloads
// - up mode edge also reloads, sets flag
// - down enabled, trigger high: count up
// - trigger low: down, underflow at reload
// - up/down: edge flag toggles, no interrupt
// - baud selects put timer in baud mode
// - baud mode rollover reloads count
// - serial bit rate is overflow over 16
// - machine cycle tick, state time in baud
// - baud rollover sets no flag, no interrupt
// - baud mode edge sets flag, no reload
// - clock-out: square wave, gated by run
// - clock-out rate osc/(4*(65536-reload))
// - clock-out rollover no interrupt, shares reload
// - mode select: baud, capture, reload, off
// - counter_select counts external input falls
// - interrupt: overflow flag OR edge flag outside up/down, software clears
module crt_timer (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        clkEn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        triggerPin,
   input  wire logic        countPin,
   output logic             timerIrq,
   output logic             txBitClk,
   output logic             rxBitClk,
   output logic             clockOut,
   output logic             clockOutEn
);
   logic [7:0]  control;
   logic [1:0]  mode;
   logic [15:0] count;
   logic [15:0] reload;
   logic [3:0]  prescale;
   logic [3:0]  baudDiv;
   logic        trigSample;
   logic        countSample;
   logic        trigLevel;
   logic        countLevel;

   crt_pin_sync u_trig_sync (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .clkEn    (clkEn),
      .pinIn    (triggerPin),
      .pinLevel (trigLevel)
   );

   crt_pin_sync u_count_sync (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .clkEn    (clkEn),
      .pinIn    (countPin),
      .pinLevel (countLevel)
   );

   // control fields
   wire reloadSel  = control[crt_pkg::CTL_RELOAD_SEL];
   wire counterSel = control[crt_pkg::CTL_COUNTER];
   wire run        = control[crt_pkg::CTL_RUN];
   wire edgeEn     = control[crt_pkg::CTL_EDGE_EN];
   wire txBaud     = control[crt_pkg::CTL_TX_BAUD];
   wire rxBaud     = control[crt_pkg::CTL_RX_BAUD];
   wire edgeFlag   = control[crt_pkg::CTL_EDGE_FLAG];
   wire ovfFlag    = control[crt_pkg::CTL_OVF_FLAG];
   wire downEn     = mode[crt_pkg::MOD_DOWN_EN];
   wire clkOutEn   = mode[crt_pkg::MOD_CLKOUT_EN];

   // mode decode
   wire baudMode    = txBaud | rxBaud;
   wire captureMode = !baudMode && reloadSel;
   wire reloadMode  = !baudMode && !reloadSel;
   wire upDownMode  = reloadMode && downEn;
   // clock-out needs the fast tick, same as baud
   wire clkOutMode  = clkOutEn && !counterSel;
   wire fastTick    = baudMode || clkOutMode;

   // one ref_clk cycle stands for one oscillator period
   wire machineTick = clkEn && (prescale == crt_pkg::MACHINE_LAST);
   wire stateTick   = clkEn && prescale[0];

   // edges only seen at machine-cycle samples
   wire trigFall  = machineTick && trigSample && !trigLevel;
   wire countFall = machineTick && countSample && !countLevel;

   // count enable: timer ticks or external falls
   wire timerTick = fastTick ? stateTick : machineTick;
   wire countStep = run && (counterSel ? countFall : timerTick);

   wire countUp   = !upDownMode || trigLevel;
   wire atTop     = count == crt_pkg::COUNT_TOP;
   wire overflow  = countStep && countUp && atTop;
   wire underflow = countStep && !countUp && (count == reload);
   wire roll      = overflow || underflow;

   // edge reload only in plain up auto-reload
   wire edgeHit    = run && edgeEn && trigFall;
   wire edgeReload = edgeHit && reloadMode && !downEn;
   wire edgeCap    = edgeHit && captureMode;

   // flags: hardware set beats same-cycle software clear
   wire ovfSet   = roll && !baudMode && !clkOutMode;
   wire edgeSet  = edgeHit && !upDownMode;
   wire edgeTog  = roll && upDownMode;

   // apb decode: zero-wait, answer in access phase
   wire apbAccess = psel && penable;
   wire apbWrite  = apbAccess && pwrite && clkEn;
   wire wrControl = apbWrite && (paddr == crt_pkg::ADDR_CONTROL);
   wire wrMode    = apbWrite && (paddr == crt_pkg::ADDR_MODE);
   wire wrCount   = apbWrite && (paddr == crt_pkg::ADDR_COUNT);
   wire wrReload  = apbWrite && (paddr == crt_pkg::ADDR_RELOAD);
   wire mapped    = paddr == crt_pkg::ADDR_CONTROL ||
                    paddr == crt_pkg::ADDR_MODE    ||
                    paddr == crt_pkg::ADDR_COUNT   ||
                    paddr == crt_pkg::ADDR_RELOAD;

   logic [31:0] readMux;
   always_comb begin
      case (paddr)
         crt_pkg::ADDR_CONTROL: readMux = {24'h000000, control};
         crt_pkg::ADDR_MODE:    readMux = {30'h00000000, mode};
         crt_pkg::ADDR_COUNT:   readMux = {16'h0000, count};
         crt_pkg::ADDR_RELOAD:  readMux = {16'h0000, reload};
         default:               readMux = 32'h00000000;
      endcase
   end

   // control register with hardware flag updates
   logic [7:0] next_control;
   always_comb begin
      next_control = wrControl ? pwdata[7:0] : control;
      if (ovfSet) begin
         next_control[crt_pkg::CTL_OVF_FLAG] = 1'b1;
      end
      if (edgeSet) begin
         next_control[crt_pkg::CTL_EDGE_FLAG] = 1'b1;
      end
      if (edgeTog) begin
         next_control[crt_pkg::CTL_EDGE_FLAG] = !edgeFlag;
      end
   end

   // count: overflow reloads except in capture, underflow loads top; a count step beats a software write
   logic [15:0] next_count;
   always_comb begin
      next_count = count;
      if (wrCount) begin
         next_count = pwdata[15:0];
      end
      if (countStep) begin
         next_count = countUp ? 16'(count + 16'h0001)
                              : 16'(count - 16'h0001);
      end
      if (overflow && !captureMode) begin
         next_count = reload;
      end
      if (underflow) begin
         next_count = crt_pkg::COUNT_TOP;
      end
      if (edgeReload) begin
         next_count = reload;
      end
   end

   // capture has priority over a software reload write
   logic [15:0] next_reload;
   assign next_reload = edgeCap ? count
                      : (wrReload ? pwdata[15:0] : reload);

   // interrupt: up/down toggles of edge flag do not request
   wire next_irq = next_control[crt_pkg::CTL_OVF_FLAG] ||
                   (next_control[crt_pkg::CTL_EDGE_FLAG] &&
                    !upDownMode);

   // baud: roll rate over 16, each serial direction if selected
   wire baudRoll = roll && baudMode;
   wire baudEdge = baudRoll && (baudDiv == crt_pkg::BAUD_LAST);

   // clock-out: toggle per roll gives osc/(4*(65536-reload))
   wire clkToggle = roll && clkOutMode;

   // apb answer registered off the setup cycle: no wait states,
   // and the access phase always sees a settled answer
   wire        setupPhase   = psel && !penable;
   wire        next_pslverr = setupPhase && !mapped;
   wire [31:0] next_prdata  = (setupPhase && !pwrite) ? readMux
                                                      : 32'h00000000;

   // one short register process per state element
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         control <= crt_pkg::CONTROL_RESET;
      end else if (clkEn) begin
         control <= next_control;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mode <= crt_pkg::MODE_RESET;
      end else if (clkEn) begin
         if (wrMode) begin
            mode <= pwdata[1:0];
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         count <= crt_pkg::COUNT_RESET;
      end else if (clkEn) begin
         count <= next_count;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         reload <= crt_pkg::RELOAD_RESET;
      end else if (clkEn) begin
         reload <= next_reload;
      end
   end

   // prescaler wraps every machine cycle
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         prescale <= '0;
      end else if (clkEn) begin
         prescale <= machineTick ? '0 : 4'(prescale + 4'h1);
      end
   end

   // sampled pin levels; edge needs high then low sample
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         trigSample <= 1'b0;
      end else if (clkEn) begin
         if (machineTick) begin
            trigSample <= trigLevel;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         countSample <= 1'b0;
      end else if (clkEn) begin
         if (machineTick) begin
            countSample <= countLevel;
         end
      end
   end

   // divider runs only while baud rollovers come
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         baudDiv <= '0;
      end else if (clkEn) begin
         if (baudRoll) begin
            baudDiv <= 4'(baudDiv + 4'h1);
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         txBitClk <= 1'b0;
      end else if (clkEn) begin
         txBitClk <= baudEdge && txBaud;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rxBitClk <= 1'b0;
      end else if (clkEn) begin
         rxBitClk <= baudEdge && rxBaud;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         clockOut <= 1'b0;
      end else if (clkEn) begin
         if (clkToggle) begin
            clockOut <= !clockOut;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         clockOutEn <= 1'b0;
      end else if (clkEn) begin
         clockOutEn <= clkOutMode;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         timerIrq <= 1'b0;
      end else if (clkEn) begin
         timerIrq <= next_irq;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pready <= 1'b0;
      end else if (clkEn) begin
         pready <= setupPhase;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pslverr <= 1'b0;
      end else if (clkEn) begin
         pslverr <= next_pslverr;
      end
   end

   // read data only in the answer cycle, zero otherwise
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         prdata <= 32'h00000000;
      end else if (clkEn) begin
         prdata <= next_prdata;
      end
   end
endmodule : crt_timer

// file: verif/crt_timer_properties.sv
`timescale 1ns/100ps
module crt_timer_properties (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clkEn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic timerIrq,
   input wire logic txBitClk,
   input wire logic rxBitClk,
   input wire logic clockOut,
   input wire logic clockOutEn
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   property p_ready; psel && !penable && clkEn |=> pready; endproperty
   a_ready: assert property (p_ready) else $error("setup unanswered");
   property p_once; pready |-> psel && penable ##1 !pready; endproperty
   a_once: assert property (p_once) else $error("ready not single");
   property p_idle; psel && !penable |-> !pready; endproperty
   a_idle: assert property (p_idle) else $error("ready in setup");
   property p_cause; pready |-> $past(psel) && !$past(penable); endproperty
   a_cause: assert property (p_cause) else $error("ready uncaused");
   property p_quiet; $fell(rst) |-> !timerIrq && !clockOutEn; endproperty
   a_quiet: assert property (p_quiet) else $error("busy after reset");
   property p_txgap; $rose(txBitClk) |=> !txBitClk [*8]; endproperty
   a_txgap: assert property (p_txgap) else $error("tx clock too fast");
   property p_rxgap; $rose(rxBitClk) |=> !rxBitClk [*8]; endproperty
   a_rxgap: assert property (p_rxgap) else $error("rx clock too fast");
   property p_hold;
      clockOutEn && $changed(clockOut) |=> $stable(clockOut) || !clockOutEn;
   endproperty
   a_hold: assert property (p_hold) else $error("clock out too fast");
endmodule : crt_timer_properties

bind crt_timer crt_timer_properties u_props (.ref_clk, .rst, .clkEn, .psel,
   .penable, .pready, .timerIrq, .txBitClk, .rxBitClk, .clockOut,
   .clockOutEn);

// file: verif/crt_pin_model.sv
`timescale 1ns/100ps
module crt_pin_model (
   input  wire logic ref_clk,
   input  wire logic trigLevel,
   input  wire logic countLevel,
   input  wire logic txBitClk,
   input  wire logic rxBitClk,
   input  wire logic clockOut,
   output logic      triggerPin,
   output logic      countPin,
   output int        txN,
   output int        rxN,
   output int        outRises
);
   logic lastOut = 1'b0;
   // pins always driven, never released
   assign triggerPin = trigLevel;
   assign countPin = countLevel;
   initial {txN, rxN, outRises} = '0;
   always @(posedge ref_clk) begin
      txN <= txN + int'(txBitClk === 1'b1);
      rxN <= rxN + int'(rxBitClk === 1'b1);
      outRises <= outRises + int'(clockOut === 1'b1 && !lastOut);
      lastOut <= clockOut;
   end
endmodule : crt_pin_model

// file: verif/tb_capture_reload_baud_timer.sv
`timescale 1ns/100ps
module tb_capture_reload_baud_timer;
   logic        ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, trigLevel = 1'b1, countLevel = 1'b1, e;
   logic        clkEn = 1'b1;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, d;
   logic        pready, pslverr, timerIrq, txBitClk, rxBitClk;
   logic        clockOut, clockOutEn, triggerPin, countPin;
   logic [15:0] r;
   int          num_errors = 0, total_checks = 0, cyc = 0, n, k, t0, x0;
   int          txN, rxN, outRises;
   // control, mode, count, reload, then an unmapped word
   logic [7:0]  adr [5] = '{crt_pkg::ADDR_CONTROL, crt_pkg::ADDR_MODE,
      crt_pkg::ADDR_COUNT, crt_pkg::ADDR_RELOAD, 8'h10};
   crt_timer DUT (.ref_clk, .rst, .clkEn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .triggerPin, .countPin,
      .timerIrq, .txBitClk, .rxBitClk, .clockOut, .clockOutEn);
   crt_pin_model PIN (.ref_clk, .trigLevel, .countLevel, .txBitClk,
      .rxBitClk, .clockOut, .triggerPin, .countPin, .txN, .rxN, .outRises);
   always #5 ref_clk = ~ref_clk;
   task automatic complete_run;
      if (num_errors == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : complete_run
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         complete_run;
      end
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      total_checks++;
      if (s !== x) begin
         num_errors++;
         $display("ERROR at %0t: seen %h expected %h", $time, s, x);
      end
   endtask : chk
   // idle edge first so psel is never set twice in one step
   task automatic apb(input logic w, input int i, input logic [31:0] wd);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= adr[i];
      pwdata <= wd;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      d = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic waitIrq;
      n = 0;
      while (timerIrq !== 1'b1 && n < 400) begin
         @(posedge ref_clk);
         n++;
      end
   endtask : waitIrq
   task automatic waitFor(input int c);
      repeat (c) @(posedge ref_clk);
   endtask : waitFor
   initial begin
      n = $urandom(32'hdab2);
      waitFor(10);
      rst <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, i, 32'h0);
         chk(d, 32'h0);
         chk(e, i == 4);
      end
      r = 16'($urandom) | 16'h8000;
      apb(1'b1, 3, {16'h0, r});
      apb(1'b1, 2, 32'hfffe);
      apb(1'b1, 0, 32'h04);
      waitIrq;
      chk(timerIrq, 1'b1);
      apb(1'b1, 0, 32'h80);
      apb(1'b0, 2, 32'h0);
      chk((d[15:0] - r) <= 1, 1'b1);
      apb(1'b0, 0, 32'h0);
      chk(d, 32'h80);
      apb(1'b1, 0, 32'h0);
      waitFor(2);
      chk(timerIrq, 1'b0);
      apb(1'b1, 2, 32'h1234);
      apb(1'b1, 0, 32'h0d);
      trigLevel <= 1'b0;
      waitIrq;
      chk(timerIrq, 1'b1);
      apb(1'b1, 0, 32'h49);
      apb(1'b0, 0, 32'h0);
      chk(d, 32'h49);
      apb(1'b0, 3, 32'h0);
      chk(d[15:0] - 16'h1234 < 16, 1'b1);
      r = 16'($urandom) & 16'h7fff;
      apb(1'b1, 0, 32'h0);
      apb(1'b1, 1, 32'h1);
      apb(1'b1, 3, {16'h0, r});
      apb(1'b1, 2, {16'h0, r + 16'h2});
      apb(1'b1, 0, 32'h04);
      waitIrq;
      apb(1'b0, 0, 32'h0);
      chk(d, 32'hc4);
      apb(1'b1, 0, 32'h40);
      apb(1'b0, 2, 32'h0);
      chk(d[15:0] > 16'hfffb, 1'b1);
      waitFor(2);
      chk(timerIrq, 1'b0);
      apb(1'b1, 1, 32'h0);
      apb(1'b1, 0, 32'h0);
      apb(1'b1, 2, 32'h0100);
      apb(1'b1, 0, 32'h06);
      k = 1 + $urandom % 4;
      repeat (k) begin
         countLevel <= 1'b0;
         waitFor(24);
         countLevel <= 1'b1;
         waitFor(24);
      end
      apb(1'b1, 0, 32'h0);
      apb(1'b0, 2, 32'h0);
      chk(d, 32'h100 + k);
      apb(1'b1, 3, 32'hfffc);
      for (int b = 0; b < 2; b++) begin
         trigLevel <= 1'b1;
         apb(1'b1, 2, 32'hfffc);
         t0 = txN;
         x0 = rxN;
         apb(1'b1, 0, b ? 32'h2c : 32'h14);
         waitFor(24);
         trigLevel <= 1'b0;
         waitFor(1000);
         apb(1'b0, 0, 32'h0);
         chk(d, b ? 32'h6c : 32'h14);
         apb(1'b1, 0, 32'h0);
         chk((b ? rxN - x0 : txN - t0) inside {[7:9]}, 1'b1);
         chk(b ? txN - t0 : rxN - x0, 0);
      end
      apb(1'b1, 1, 32'h2);
      apb(1'b1, 3, 32'hfff0);
      apb(1'b1, 0, 32'h04);
      t0 = outRises;
      waitFor(640);
      chk(clockOutEn, 1'b1);
      chk((outRises - t0) inside {[9:11]}, 1'b1);
      // clock enable low must freeze the square wave
      clkEn <= 1'b0;
      waitFor(2);
      r[0] = clockOut;
      waitFor(40);
      chk(clockOut, r[0]);
      clkEn <= 1'b1;
      apb(1'b0, 0, 32'h0);
      chk(d, 32'h04);
      complete_run;
   end
endmodule : tb_capture_reload_baud_timer
